// ==== logic/pam_regs.sv ====
// Management register bank of the physical-attachment layer, reached by management frames
`timescale 1ns/100ps

// Overview of operation
// - Permit bit 2 enables preset transmit load
// - Attachment registers only via device address one
// - Vendor space also reached via address thirty
// - Control bit 15 resets all, self-clearing
// - Control bit 11 requests low power
// - Control bit 0 enables line-side loopback
// - Fault bit clears after second status read
// - Latched transmit and receive faults, clear-on-read
// - Link bit latches low until read
// - Low-power capable always reads one
// - Identifier high at two, low at three
// - Identifier packs organization, model, revision
// - Speed capability reads 0x0011
// - Reserved control and permit bits read zero
module pam_regs #(
  parameter logic [4:0] PORT_ADDR = 5'h00,
  parameter logic [15:0] ID_ORG_HIGH = 16'h2C5A, // Arbitrary value
  parameter logic [5:0] ID_ORG_LOW = 6'h1D, // Arbitrary value
  parameter logic [5:0] ID_MODEL = 6'h2B, // Arbitrary value
  parameter logic [3:0] ID_REVISION = 4'h7 // Arbitrary value
) (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic mdc, // Management clock pin
  input wire logic mdio_in, // Management data pin level
  output logic mdio_out, // Management data drive value
  output logic mdio_oe_n, // Management data drive enable, low drives
  input wire pam_pkg::pam_line_status_t line_status, // Datapath fault and link levels
  output logic low_power_request, // Power-down request
  output logic loopback_en, // Line-side loopback enable
  output logic tx_preset_permit, // Preset transmit load permitted
  output logic core_reset // One-cycle reset pulse to datapath
);

  pam_pkg::pam_pins_t pins_s;
  pam_pkg::pam_state_t s_q;
  pam_pkg::pam_state_t s_d;
  logic mdc_rise;
  logic hdr_done;
  logic hit;
  logic rd_cap;
  logic wr_done;
  logic wr_ctrl;
  logic wr_permit;
  logic [12:0] hdr_new;
  logic [15:0] rd_word;
  logic [15:0] cur_addr;
  logic [15:0] wr_word;
  logic soft_rst;
  logic stat1_rd;
  logic stat2_rd;

  pam_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({mdc, mdio_in}),
    .sync_out(pins_s)
  );

  assign mdc_rise = pins_s.mdc & ~s_q.mdc_prev;
  assign hdr_new = {s_q.hdr[11:0], pins_s.mdio};
  assign hdr_done = mdc_rise && s_q.phase == pam_pkg::PAM_HDR && s_q.bit_cnt == pam_pkg::HDR_LAST;
  // Clause 45 start, our port, one of the two spaces we serve
  assign hit = !hdr_new[12] && hdr_new[9:5] == PORT_ADDR &&
    (hdr_new[4:0] == pam_pkg::DEVAD_ATTACH || hdr_new[4:0] == pam_pkg::DEVAD_VENDOR);
  assign rd_cap = hdr_done && hit && hdr_new[11];
  assign cur_addr = (hdr_new[4:0] == pam_pkg::DEVAD_ATTACH) ? s_q.addr_attach : s_q.addr_vendor;
  assign wr_word = {s_q.shreg[14:0], pins_s.mdio};
  assign wr_done = mdc_rise && s_q.phase == pam_pkg::PAM_DATA && s_q.bit_cnt == pam_pkg::DATA_LAST &&
    s_q.hdr[11:10] == pam_pkg::OP_WRITE;
  assign wr_ctrl = wr_done && s_q.hdr[4:0] == pam_pkg::DEVAD_ATTACH && s_q.addr_attach == pam_pkg::REG_CONTROL;
  assign wr_permit = wr_done && s_q.hdr[4:0] == pam_pkg::DEVAD_VENDOR && s_q.addr_vendor == pam_pkg::REG_TX_PERMIT;
  assign soft_rst = wr_ctrl && wr_word[pam_pkg::CTRL_RESET_BIT];
  assign stat1_rd = rd_cap && hdr_new[4:0] == pam_pkg::DEVAD_ATTACH && cur_addr == pam_pkg::REG_STATUS;
  assign stat2_rd = rd_cap && hdr_new[4:0] == pam_pkg::DEVAD_ATTACH && cur_addr == pam_pkg::REG_STATUS2;

  // Read mux, decoded from the header just completed
  always_comb begin
    rd_word = pam_pkg::READ_UNMAPPED;
    if (hdr_new[4:0] == pam_pkg::DEVAD_VENDOR) begin
      if (cur_addr == pam_pkg::REG_TX_PERMIT) begin
        rd_word[pam_pkg::PERMIT_BIT] = s_q.tx_preset_permit;
      end
    end else if (cur_addr == pam_pkg::REG_CONTROL) begin
      // Reset bit self-clears, reserved bits stay zero
      rd_word[pam_pkg::CTRL_LOW_POWER_BIT] = s_q.low_power_request;
      rd_word[pam_pkg::CTRL_LOOPBACK_BIT] = s_q.loopback_en;
    end else if (cur_addr == pam_pkg::REG_STATUS) begin
      rd_word = pam_pkg::STATUS_RESET;
      rd_word[pam_pkg::STAT_FAULT_BIT] = s_q.tx_fault_lh | s_q.rx_fault_lh;
      rd_word[pam_pkg::STAT_LINK_BIT] = s_q.rx_link_ll;
    end else if (cur_addr == pam_pkg::REG_ID_HIGH) begin
      rd_word = ID_ORG_HIGH;
    end else if (cur_addr == pam_pkg::REG_ID_LOW) begin
      rd_word = {ID_ORG_LOW, ID_MODEL, ID_REVISION};
    end else if (cur_addr == pam_pkg::REG_SPEED_CAP) begin
      rd_word = pam_pkg::SPEED_CAP_VALUE;
    end else if (cur_addr == pam_pkg::REG_STATUS2) begin
      rd_word = pam_pkg::STATUS2_FIXED;
      rd_word[pam_pkg::STAT2_TX_FAULT_BIT] = s_q.tx_fault_lh;
      rd_word[pam_pkg::STAT2_RX_FAULT_BIT] = s_q.rx_fault_lh;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.mdc_prev = pins_s.mdc;
    s_d.core_reset = 1'b0;
    // Latches track the line every cycle; reads below reload them
    s_d.tx_fault_lh = s_q.tx_fault_lh | line_status.tx_fault;
    s_d.rx_fault_lh = s_q.rx_fault_lh | line_status.rx_fault;
    s_d.rx_link_ll = s_q.rx_link_ll & line_status.rx_link;
    if (mdc_rise) begin
      case (s_q.phase)
        pam_pkg::PAM_PRE: begin
          if (pins_s.mdio) begin
            if (s_q.pre_cnt != pam_pkg::PREAMBLE_MIN) begin
              s_d.pre_cnt = s_q.pre_cnt + 6'h01;
            end
          end else begin
            if (s_q.pre_cnt == pam_pkg::PREAMBLE_MIN) begin
              s_d.phase = pam_pkg::PAM_HDR;
              s_d.bit_cnt = '0;
            end
            s_d.pre_cnt = '0;
          end
        end
        pam_pkg::PAM_HDR: begin
          s_d.hdr = hdr_new;
          s_d.bit_cnt = s_q.bit_cnt + 5'h01;
          if (hdr_done) begin
            s_d.bit_cnt = '0;
            // Foreign frames are dropped; the pin is never driven for them
            s_d.phase = hit ? pam_pkg::PAM_TA : pam_pkg::PAM_PRE;
            if (rd_cap) begin
              s_d.shreg = rd_word;
              if (hdr_new[11:10] == pam_pkg::OP_READ_INC) begin
                if (hdr_new[4:0] == pam_pkg::DEVAD_ATTACH) begin
                  s_d.addr_attach = s_q.addr_attach + 16'h0001;
                end else begin
                  s_d.addr_vendor = s_q.addr_vendor + 16'h0001;
                end
              end
              // Clear-on-read, but a fault still present keeps its flag
              if (hdr_new[4:0] == pam_pkg::DEVAD_ATTACH && cur_addr == pam_pkg::REG_STATUS2) begin
                s_d.tx_fault_lh = line_status.tx_fault;
                s_d.rx_fault_lh = line_status.rx_fault;
              end
              if (hdr_new[4:0] == pam_pkg::DEVAD_ATTACH && cur_addr == pam_pkg::REG_STATUS) begin
                s_d.rx_link_ll = line_status.rx_link;
              end
            end
          end
        end
        pam_pkg::PAM_TA: begin
          s_d.bit_cnt = s_q.bit_cnt + 5'h01;
          if (s_q.bit_cnt == 5'h00) begin
            if (s_q.hdr[11]) begin
              s_d.mdio_oe_n = 1'b0;
              s_d.mdio_out = 1'b0;
            end
          end else begin
            s_d.phase = pam_pkg::PAM_DATA;
            s_d.bit_cnt = '0;
            if (s_q.hdr[11]) begin
              s_d.mdio_out = s_q.shreg[15];
              s_d.shreg = {s_q.shreg[14:0], 1'b0};
            end
          end
        end
        pam_pkg::PAM_DATA: begin
          s_d.bit_cnt = s_q.bit_cnt + 5'h01;
          if (s_q.hdr[11]) begin
            s_d.mdio_out = s_q.shreg[15];
            s_d.shreg = {s_q.shreg[14:0], 1'b0};
          end else begin
            s_d.shreg = wr_word;
          end
          if (s_q.bit_cnt == pam_pkg::DATA_LAST) begin
            s_d.phase = pam_pkg::PAM_PRE;
            s_d.mdio_oe_n = 1'b1;
            s_d.mdio_out = 1'b1;
            if (s_q.hdr[11:10] == pam_pkg::OP_ADDRESS) begin
              if (s_q.hdr[4:0] == pam_pkg::DEVAD_ATTACH) begin
                s_d.addr_attach = wr_word;
              end else begin
                s_d.addr_vendor = wr_word;
              end
            end
            // Writes to other offsets, fixed or unmapped, are dropped
            if (wr_ctrl) begin
              s_d.low_power_request = wr_word[pam_pkg::CTRL_LOW_POWER_BIT];
              s_d.loopback_en = wr_word[pam_pkg::CTRL_LOOPBACK_BIT];
            end
            if (wr_permit) begin
              // Load strobe itself lives elsewhere and only acts while this is set
              s_d.tx_preset_permit = wr_word[pam_pkg::PERMIT_BIT];
            end
          end
        end
        default: begin
          s_d.phase = pam_pkg::PAM_PRE;
        end
      endcase
    end
    if (wr_ctrl && wr_word[pam_pkg::CTRL_RESET_BIT]) begin
      // Same effect as the hardware reset; bit never stored so it reads back zero
      s_d = pam_pkg::STATE_RESET;
      s_d.core_reset = 1'b1;
      s_d.mdc_prev = pins_s.mdc;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= pam_pkg::STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign mdio_out = s_q.mdio_out;
  assign mdio_oe_n = s_q.mdio_oe_n;
  assign low_power_request = s_q.low_power_request;
  assign loopback_en = s_q.loopback_en;
  assign tx_preset_permit = s_q.tx_preset_permit;
  assign core_reset = s_q.core_reset;

  a_soft_reset_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl && wr_word[15] |=> core_reset && !low_power_request && !loopback_en ##1 !core_reset)
    else $error("control reset bit did not give a one-cycle reset");
  a_low_power_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl && !wr_word[15] |=> low_power_request == $past(wr_word[11]))
    else $error("low power request does not follow control write");
  a_loopback_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl && !wr_word[15] |=> loopback_en == $past(wr_word[0]))
    else $error("loopback enable does not follow control write");
  a_permit_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_permit |=> tx_preset_permit == $past(wr_word[2]))
    else $error("preset permit does not follow write");
  a_fault_summary: assert property (@(posedge sys_clk) disable iff (rst)
    rd_cap && cur_addr == 16'h0001 && hdr_new[4:0] == 5'h01 |-> rd_word[7] == (s_q.tx_fault_lh | s_q.rx_fault_lh))
    else $error("fault summary bit wrong");
  a_fault_latched: assert property (@(posedge sys_clk) disable iff (rst)
    line_status.tx_fault && !soft_rst |=> s_q.tx_fault_lh)
    else $error("transmit fault not latched");
  a_link_latch_low: assert property (@(posedge sys_clk) disable iff (rst)
    !line_status.rx_link |=> !s_q.rx_link_ll)
    else $error("link loss not latched low");
  a_fixed_speed_cap: assert property (@(posedge sys_clk) disable iff (rst)
    rd_cap && cur_addr == 16'h0004 && hdr_new[4:0] == 5'h01 |-> rd_word == 16'h0011)
    else $error("speed capability value wrong");
  a_status_fixed_bit: assert property (@(posedge sys_clk) disable iff (rst)
    rd_cap && cur_addr == 16'h0001 && hdr_new[4:0] == 5'h01 |-> rd_word[1] && rd_word[15:8] == 8'h00)
    else $error("low power capable bit not set");
  a_foreign_dropped: assert property (@(posedge sys_clk) disable iff (rst)
    hdr_done && !hit |=> s_q.phase == pam_pkg::PAM_PRE && mdio_oe_n [*2])
    else $error("foreign frame was not dropped");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
    rd_cap && cur_addr == 16'h0000 && hdr_new[4:0] == 5'h01 |-> rd_word[15:12] == 4'h0 && rd_word[10:1] == 10'h000)
    else $error("reserved control bits not zero");
  a_id_high_fixed: assert property (@(posedge sys_clk) disable iff (rst)
    rd_cap && cur_addr == pam_pkg::REG_ID_HIGH && hdr_new[4:0] == pam_pkg::DEVAD_ATTACH |->
    rd_word == ID_ORG_HIGH)
    else $error("identifier high word wrong");
  a_id_low_fields: assert property (@(posedge sys_clk) disable iff (rst)
    rd_cap && cur_addr == pam_pkg::REG_ID_LOW && hdr_new[4:0] == pam_pkg::DEVAD_ATTACH |->
    rd_word[15:10] == ID_ORG_LOW && rd_word[9:4] == ID_MODEL && rd_word[3:0] == ID_REVISION)
    else $error("identifier low word fields wrong");
  a_permit_reserved: assert property (@(posedge sys_clk) disable iff (rst)
    rd_cap && cur_addr == pam_pkg::REG_TX_PERMIT && hdr_new[4:0] == pam_pkg::DEVAD_VENDOR |->
    rd_word[15:3] == 13'h0 && rd_word[1:0] == 2'h0)
    else $error("reserved permit bits not zero");
  a_fault_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.tx_fault_lh || s_q.rx_fault_lh) && !stat2_rd && !soft_rst |=> s_q.tx_fault_lh || s_q.rx_fault_lh)
    else $error("fault summary cleared without second status read");
  a_link_hold_low: assert property (@(posedge sys_clk) disable iff (rst)
    !s_q.rx_link_ll && !stat1_rd |=> !s_q.rx_link_ll)
    else $error("link latch rose without a status read");
  a_drive_in_read: assert property (@(posedge sys_clk) disable iff (rst)
    !mdio_oe_n |-> s_q.hdr[11] && (s_q.phase == pam_pkg::PAM_TA || s_q.phase == pam_pkg::PAM_DATA))
    else $error("data pin driven outside a read frame");
  a_permit_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !wr_permit && !soft_rst |=> $stable(tx_preset_permit))
    else $error("preset permit changed without a write");
  a_control_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !wr_ctrl |=> $stable(low_power_request) && $stable(loopback_en))
    else $error("control bits changed without a write");

  c_read_frame: cover property (@(posedge sys_clk) disable iff (rst) rd_cap ##[1:1000] !mdio_oe_n);
  c_control_write: cover property (@(posedge sys_clk) disable iff (rst) wr_ctrl);
  c_permit_write: cover property (@(posedge sys_clk) disable iff (rst) wr_permit);
  c_soft_reset: cover property (@(posedge sys_clk) disable iff (rst) core_reset);
  c_status2_read: cover property (@(posedge sys_clk) disable iff (rst) stat2_rd);

endmodule

// ==== logic/pam_pkg.sv ====
// Constants and state types of the physical-attachment management register bank
package pam_pkg;

  // Management frame fields
  localparam logic [4:0] DEVAD_ATTACH = 5'h01;
  localparam logic [4:0] DEVAD_VENDOR = 5'h1E;
  localparam logic [1:0] OP_ADDRESS = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  localparam logic [5:0] PREAMBLE_MIN = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0C;
  localparam logic [4:0] DATA_LAST = 5'h0F;

  // Register offsets
  localparam logic [15:0] REG_CONTROL = 16'h0000;
  localparam logic [15:0] REG_STATUS = 16'h0001;
  localparam logic [15:0] REG_ID_HIGH = 16'h0002;
  localparam logic [15:0] REG_ID_LOW = 16'h0003;
  localparam logic [15:0] REG_SPEED_CAP = 16'h0004;
  localparam logic [15:0] REG_STATUS2 = 16'h0008;
  localparam logic [15:0] REG_TX_PERMIT = 16'h8101;

  // Field positions
  localparam int CTRL_RESET_BIT = 15;
  localparam int CTRL_LOW_POWER_BIT = 11;
  localparam int CTRL_LOOPBACK_BIT = 0;
  localparam int STAT_FAULT_BIT = 7;
  localparam int STAT_LINK_BIT = 2;
  localparam int STAT_LOW_POWER_CAPABLE_BIT = 1;
  localparam int STAT2_TX_FAULT_BIT = 11;
  localparam int STAT2_RX_FAULT_BIT = 10;
  localparam int PERMIT_BIT = 2;

  // Fixed read values
  localparam logic [15:0] STATUS_RESET = 16'h0002;
  localparam logic [15:0] SPEED_CAP_VALUE = 16'h0011;
  localparam logic [15:0] STATUS2_FIXED = 16'hB000;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;

  typedef enum logic [1:0] {PAM_PRE, PAM_HDR, PAM_TA, PAM_DATA} pam_phase_t;

  typedef struct packed {
    pam_phase_t phase;
    logic [5:0] pre_cnt;
    logic [4:0] bit_cnt;
    logic [12:0] hdr;
    logic [15:0] shreg;
    logic mdc_prev;
    logic [15:0] addr_attach;
    logic [15:0] addr_vendor;
    logic low_power_request;
    logic loopback_en;
    logic tx_preset_permit;
    logic core_reset;
    logic tx_fault_lh;
    logic rx_fault_lh;
    logic rx_link_ll;
    logic mdio_out;
    logic mdio_oe_n;
  } pam_state_t;

  localparam pam_state_t STATE_RESET = '{phase: PAM_PRE, mdio_out: 1'b1, mdio_oe_n: 1'b1, default: '0};

  typedef struct packed {
    logic mdc;
    logic mdio;
  } pam_pins_t;

  typedef struct packed {
    logic tx_fault;
    logic rx_fault;
    logic rx_link;
  } pam_line_status_t;

endpackage

// ==== logic/pam_sync.sv ====
// Two-flop synchroniser for management pins
`timescale 1ns/100ps
module pam_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [WIDTH-1:0] async_in, // Pin levels
  output logic [WIDTH-1:0] sync_out // Resynchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pam_sync_state_t;

  pam_sync_state_t s_q;
  pam_sync_state_t s_d;

  always_comb begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule

// ==== sim/pam_host.sv ====
// Management host model that sends frames to the register bank
`timescale 1ns/100ps
module pam_host #(
  parameter logic [4:0] PRTAD = 5'h05
) (
  input wire logic sys_clk, // System clock
  input wire logic bus_level, // Resolved data line
  output logic mdc, // Management clock
  output logic host_d, // Host data
  output logic host_en // High while host drives
);
  initial begin
    mdc = 1'b0;
    host_d = 1'b1;
    host_en = 1'b0;
  end

  // Three system cycles low and four high per period, above the resync minimum
  task automatic tick(input logic d, input logic en, output logic smp);
    @(negedge sys_clk);
    mdc = 1'b0;
    host_d = d;
    host_en = en;
    repeat (3) @(negedge sys_clk);
    smp = bus_level;
    mdc = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] dev,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic [31:0] hdr;
    hdr = {st, op, PRTAD, dev, 2'b10, wd}; // Device field picks the space
    for (int i = 0; i < 32; i++) begin
      tick(1'b1, 1'b1, s);
    end
    for (int i = 31; i >= 0; i--) begin
      // Line released from the turnaround on for reads
      tick(hdr[i], !(op[1] && i < 18), s);
      if (i < 16) begin
        rd[i] = s;
      end
    end
    @(negedge sys_clk);
    mdc = 1'b0;
    host_en = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the management register bank
`timescale 1ns/100ps
module testbench;
  localparam logic [15:0] ORG_HI = 16'h3A61; // Arbitrary value
  localparam logic [15:0] ID_LO = {6'h2E, 6'h15, 4'h9}; // Arbitrary value
  logic sys_clk;
  logic rst;
  logic mdc;
  logic host_d;
  logic host_en;
  logic bus_level;
  logic mdio_out;
  logic mdio_oe_n;
  pam_pkg::pam_line_status_t line_status;
  logic low_power_request;
  logic loopback_en;
  logic tx_preset_permit;
  logic core_reset;
  logic [15:0] rd;
  int fail_count = 0;
  int cmp_count = 0;
  int pulses = 0;
  int drives = 0;
  int cycles = 0;
  int n;

  // Pull-up holds the line high when nobody drives it
  assign bus_level = host_en ? host_d : (mdio_oe_n ? 1'b1 : mdio_out);

  pam_regs #(.PORT_ADDR(5'h05), .ID_ORG_HIGH(ORG_HI), .ID_ORG_LOW(6'h2E), .ID_MODEL(6'h15),
    .ID_REVISION(4'h9)) i_pam_regs (.sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdio_in(bus_level),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .line_status(line_status),
    .low_power_request(low_power_request), .loopback_en(loopback_en),
    .tx_preset_permit(tx_preset_permit), .core_reset(core_reset));

  pam_host #(.PRTAD(5'h05)) i_pam_host (.sys_clk(sys_clk), .bus_level(bus_level), .mdc(mdc),
    .host_d(host_d), .host_en(host_en));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (core_reset === 1'b1) begin
      pulses <= pulses + 1;
    end
    if (mdio_oe_n !== 1'b1) begin
      drives <= drives + 1;
    end
    if (cycles == 60000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] d);
    i_pam_host.frame(2'b00, pam_pkg::OP_ADDRESS, dev, a, rd);
    i_pam_host.frame(2'b00, pam_pkg::OP_WRITE, dev, d, rd);
  endtask

  task automatic rdc(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] exp);
    i_pam_host.frame(2'b00, pam_pkg::OP_ADDRESS, dev, a, rd);
    i_pam_host.frame(2'b00, 2'h3, dev, 16'h0000, rd);
    chk(rd, exp);
  endtask

  task automatic t_status;
    rdc(5'h01, pam_pkg::REG_STATUS, 16'h0002);
    rdc(5'h01, pam_pkg::REG_STATUS, 16'h0006);
    @(negedge sys_clk);
    line_status.rx_link = 1'b0;
    @(negedge sys_clk);
    line_status.rx_link = 1'b1;
    rdc(5'h01, pam_pkg::REG_STATUS, 16'h0002);
    rdc(5'h01, pam_pkg::REG_STATUS, 16'h0006);
    @(negedge sys_clk);
    line_status.tx_fault = 1'b1;
    @(negedge sys_clk);
    line_status.tx_fault = 1'b0;
    rdc(5'h01, pam_pkg::REG_STATUS, 16'h0086);
    rdc(5'h01, pam_pkg::REG_STATUS2, 16'hB800);
    rdc(5'h01, pam_pkg::REG_STATUS2, 16'hB000);
    rdc(5'h01, pam_pkg::REG_STATUS, 16'h0006);
    @(negedge sys_clk);
    line_status.rx_fault = 1'b1;
    rdc(5'h01, pam_pkg::REG_STATUS2, 16'hB400);
    rdc(5'h01, pam_pkg::REG_STATUS, 16'h0086);
    @(negedge sys_clk);
    line_status.rx_fault = 1'b0;
    rdc(5'h01, pam_pkg::REG_STATUS2, 16'hB400);
    rdc(5'h01, pam_pkg::REG_STATUS, 16'h0006);
  endtask

  task automatic t_fixed;
    rdc(5'h01, pam_pkg::REG_ID_HIGH, ORG_HI);
    rdc(5'h01, pam_pkg::REG_ID_LOW, ID_LO);
    // Read with increment walks from the high to the low identifier word
    i_pam_host.frame(2'b00, pam_pkg::OP_ADDRESS, 5'h01, pam_pkg::REG_ID_HIGH, rd);
    i_pam_host.frame(2'b00, pam_pkg::OP_READ_INC, 5'h01, 16'h0000, rd);
    chk(rd, ORG_HI);
    i_pam_host.frame(2'b00, 2'h3, 5'h01, 16'h0000, rd);
    chk(rd, ID_LO);
    wr(5'h01, pam_pkg::REG_SPEED_CAP, 16'hFFEE);
    wr(5'h01, pam_pkg::REG_ID_HIGH, 16'h0000);
    wr(5'h01, pam_pkg::REG_STATUS, 16'h0000);
    rdc(5'h01, pam_pkg::REG_SPEED_CAP, 16'h0011);
    rdc(5'h01, pam_pkg::REG_ID_HIGH, ORG_HI);
    rdc(5'h01, pam_pkg::REG_STATUS, 16'h0006);
  endtask

  task automatic t_ctrl;
    wr(5'h01, pam_pkg::REG_CONTROL, 16'h7FFF);
    rdc(5'h01, pam_pkg::REG_CONTROL, 16'h0801);
    chk({14'h0, low_power_request, loopback_en}, 16'h0003);
    wr(5'h01, pam_pkg::REG_CONTROL, 16'h0001);
    chk({14'h0, low_power_request, loopback_en}, 16'h0001);
    wr(5'h01, pam_pkg::REG_CONTROL, 16'h0800);
    chk({14'h0, low_power_request, loopback_en}, 16'h0002);
    n = pulses;
    wr(5'h01, pam_pkg::REG_CONTROL, 16'h8000);
    chk(16'(pulses - n), 16'h0001);
    chk({14'h0, low_power_request, loopback_en}, 16'h0000);
    rdc(5'h01, pam_pkg::REG_CONTROL, 16'h0000);
  endtask

  task automatic t_permit;
    rdc(5'h1E, pam_pkg::REG_TX_PERMIT, 16'h0000);
    wr(5'h1E, pam_pkg::REG_TX_PERMIT, 16'hFFFF); // Permit set before any preset strobe
    chk({15'h0, tx_preset_permit}, 16'h0001);
    rdc(5'h1E, pam_pkg::REG_TX_PERMIT, 16'h0004);
    wr(5'h1E, pam_pkg::REG_TX_PERMIT, 16'h0000);
    chk({15'h0, tx_preset_permit}, 16'h0000);
  endtask

  task automatic t_refuse;
    n = drives;
    i_pam_host.frame(2'b00, pam_pkg::OP_ADDRESS, 5'h02, pam_pkg::REG_CONTROL, rd);
    i_pam_host.frame(2'b00, pam_pkg::OP_WRITE, 5'h02, 16'h0801, rd);
    i_pam_host.frame(2'b00, 2'h3, 5'h02, 16'h0000, rd);
    i_pam_host.frame(2'b01, pam_pkg::OP_WRITE, 5'h01, 16'h0801, rd);
    chk(16'(drives - n), 16'h0000);
    chk({14'h0, low_power_request, loopback_en}, 16'h0000);
    rdc(5'h01, pam_pkg::REG_CONTROL, 16'h0000);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    line_status = '{tx_fault: 1'b0, rx_fault: 1'b0, rx_link: 1'b1};
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    t_status();
    t_fixed();
    t_ctrl();
    t_permit();
    t_refuse();
    end_of_test();
  end
endmodule
